// ---- rtl/rcs_sequencer.sv ----
// Reader command sequencer: command start, abort, transmit and receive
// Behaviour
// - Command code write starts the operation
// - Stream commands consume FIFO bytes at once
// - Command start never flushes the FIFO
// - New command aborts running command
// - Start-up 3Fh only via reset, uninterruptible
// - Idle 00h terminates current command
// - Transmit 1Ah sends FIFO stream, no receive
// - Receive 16h waits guard delay, then streams
// ---------------------------------------------------------------
// Overview
// ---------------------------------------------------------------
// The sequencer sits between the host command port, the shared FIFO
// and the transmit and receive paths. One state machine holds the
// running command; the host replaces it by writing a new code.
//
// Start-up
//   Reset forces the start-up command. A fixed count of cycles then
//   runs down before the block falls to idle. Host writes arriving in
//   that window are dropped without trace, so a host must poll the
//   busy flag before its first command.
//
// Command writes
//   A write is taken on the rising edge that sees the strobe high.
//   The active code and busy flag change on that same edge. Any command
//   in progress is cut off in the same edge: a byte offered to the
//   transmitter is withdrawn, the receiver is switched off and no
//   pending pop or push survives. Codes not handled here fall back to
//   idle, which keeps the state machine in a known place when the host
//   writes something unexpected.
//
// FIFO handling
//   Command start never clears the FIFO, so bytes loaded beforehand
//   are sent. A pop is a single-cycle pulse and the next pop waits at
//   least one cycle, giving the FIFO time to advance its head. The
//   trade-off is half rate on long streams; the transmitter is slower
//   than that anyway.
//
// Transmit
//   One byte is held at a time. The valid flag stays up until the
//   transmitter signals ready; a new byte may be loaded in the cycle
//   the old one is taken.
//
// Receive
//   The guard timer is loaded at the command write with the delay
//   level present then. Changing the delay later has no effect on a
//   receive already started. Once the timer expires the receiver is
//   enabled and every received byte is pushed into the FIFO one cycle
//   after it arrives. Receive runs until the host writes a new code.
//
// Limitations
//   No back-pressure is taken from the FIFO on push; the FIFO is
//   assumed never to overflow during a receive.
`timescale 1ns/10ps
`include "rcs_cfg.svh"
module rcs_sequencer (
  input  wire logic                    sys_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    cmd_wr_i,
  input  wire logic [7:0]              cmd_code_i,
  input  wire logic [`RCS_GUARD_W-1:0] receive_guard_delay_i,
  input  wire logic                    fifo_valid_i,
  input  wire logic [7:0]              fifo_data_i,
  output logic                         fifo_pop_o,
  input  wire logic                    tx_ready_i,
  output logic                         tx_valid_o,
  output logic [7:0]                   tx_data_o,
  input  wire logic                    rx_valid_i,
  input  wire logic [7:0]              rx_data_i,
  output logic                         rx_enable_o,
  output logic                         fifo_push_o,
  output logic [7:0]                   fifo_wdata_o,
  output logic [7:0]                   active_cmd_o,
  output logic                         busy_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rcs_pkg::rcs_state_type st;
    logic [7:0]             init_cnt;
    logic [7:0]             cmd;
    logic                   pop;
    logic                   txv;
    logic [7:0]             txd;
    logic                   rxen;
    logic                   push;
    logic [7:0]             wdata;
    logic                   busy;
  } rcs_seq_type;
  rcs_seq_type state_reg;
  rcs_seq_type state_next;
  logic        guard_load;
  logic        guard_done;

  // Any code other than the ones handled here is treated as idle
  function automatic rcs_pkg::rcs_state_type decode_cmd(input logic [7:0] code);
    case (code)
      `RCS_CMD_TRANSMIT: decode_cmd = rcs_pkg::RCS_ST_TX;
      `RCS_CMD_RECEIVE:  decode_cmd = rcs_pkg::RCS_ST_RECEIVE_GUARD_DELAY;
      default:           decode_cmd = rcs_pkg::RCS_ST_IDLE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Guard delay timer
  // ---------------------------------------------------------------
  rcs_guard_timer u_guard (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (guard_load),
    .delay_i   (receive_guard_delay_i),
    .expired_o (guard_done)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Stream commands pop when a byte is present, the tx slot is free and no pop was issued last cycle; no count is awaited, so
  // no argument-gathering state exists for the commands kept here.
  always_comb
  begin
    state_next       = state_reg;
    state_next.pop   = 1'b0;
    state_next.push  = 1'b0;
    guard_load       = 1'b0;
    case (state_reg.st)
      rcs_pkg::RCS_ST_INIT:
      begin
        // Host writes are ignored until initialisation ends
        if (state_reg.init_cnt == '0)
        begin
          state_next.st  = rcs_pkg::RCS_ST_IDLE;
          state_next.cmd = `RCS_CMD_IDLE;
        end
        else
          state_next.init_cnt = state_reg.init_cnt - 8'h01;
      end
      rcs_pkg::RCS_ST_TX:
      begin
        // Hold a byte until the transmitter takes it
        if (state_reg.txv && tx_ready_i)
          state_next.txv = 1'b0;
        if ((!state_reg.txv || tx_ready_i) && fifo_valid_i && !state_reg.pop)
        begin
          state_next.pop = 1'b1;
          state_next.txv = 1'b1;
          state_next.txd = fifo_data_i;
        end
      end
      rcs_pkg::RCS_ST_RECEIVE_GUARD_DELAY:
      begin
        if (guard_done)
        begin
          state_next.st   = rcs_pkg::RCS_ST_RX;
          state_next.rxen = 1'b1;
        end
      end
      rcs_pkg::RCS_ST_RX:
      begin
        if (rx_valid_i)
        begin
          state_next.push  = 1'b1;
          state_next.wdata = rx_data_i;
        end
      end
      default:
      begin
        state_next.st = rcs_pkg::RCS_ST_IDLE;
      end
    endcase
    // A command write cancels whatever runs, except during start-up;
    // the FIFO contents are left untouched so preloaded bytes survive.
    if (cmd_wr_i && state_reg.st != rcs_pkg::RCS_ST_INIT)
    begin
      state_next.st   = decode_cmd(cmd_code_i);
      state_next.cmd  = (decode_cmd(cmd_code_i) == rcs_pkg::RCS_ST_IDLE) ?
                        `RCS_CMD_IDLE : cmd_code_i;
      state_next.txv  = 1'b0;
      state_next.pop  = 1'b0;
      state_next.push = 1'b0;
      state_next.rxen = 1'b0;
      guard_load      = (decode_cmd(cmd_code_i) == rcs_pkg::RCS_ST_RECEIVE_GUARD_DELAY);
    end
    state_next.busy = (state_next.st != rcs_pkg::RCS_ST_IDLE);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset enters the start-up command; nothing else can reach it
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      state_reg          <= '0;
      state_reg.st       <= rcs_pkg::RCS_ST_INIT;
      state_reg.init_cnt <= `RCS_INIT_CYCLES;
      state_reg.cmd      <= `RCS_CMD_POWER_UP_INIT_COMMAND;
      state_reg.busy     <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  assign fifo_pop_o   = state_reg.pop;
  assign tx_valid_o   = state_reg.txv;
  assign tx_data_o    = state_reg.txd;
  assign rx_enable_o  = state_reg.rxen;
  assign fifo_push_o  = state_reg.push;
  assign fifo_wdata_o = state_reg.wdata;
  assign active_cmd_o = state_reg.cmd;
  assign busy_o       = state_reg.busy;
endmodule // rcs_sequencer

// ---- rtl/rcs_cfg.svh ----
// Constants of the reader command sequencer
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
`define RCS_CMD_IDLE     8'h00
`define RCS_CMD_RECEIVE  8'h16
`define RCS_CMD_TRANSMIT 8'h1A
`define RCS_CMD_POWER_UP_INIT_COMMAND  8'h3F
`define RCS_INIT_CYCLES  8'h10
`define RCS_GUARD_W      8
`endif

// ---- rtl/rcs_pkg.sv ----
// Types of the reader command sequencer
package rcs_pkg;
  typedef enum logic [2:0] {
    RCS_ST_INIT,
    RCS_ST_IDLE,
    RCS_ST_TX,
    RCS_ST_RECEIVE_GUARD_DELAY,
    RCS_ST_RX
  } rcs_state_type;
endpackage

// ---- rtl/rcs_guard_timer.sv ----
// Receive guard delay down-counter
`timescale 1ns/10ps
`include "rcs_cfg.svh"
module rcs_guard_timer (
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   load_i,
  input  wire logic [`RCS_GUARD_W-1:0] delay_i,
  output logic                        expired_o
);
  typedef struct packed {
    logic [`RCS_GUARD_W-1:0] count;
    logic                    run;
    logic                    done;
  } rcs_gt_type;
  rcs_gt_type state_reg;
  rcs_gt_type state_next;

  // Load restarts the count; done pulses once it reaches zero
  always_comb
  begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (load_i)
    begin
      state_next.count = delay_i;
      state_next.run   = 1'b1;
    end
    else if (state_reg.run)
    begin
      if (state_reg.count == '0)
      begin
        state_next.run  = 1'b0;
        state_next.done = 1'b1;
      end
      else
        state_next.count = state_reg.count - 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign expired_o = state_reg.done;
endmodule // rcs_guard_timer

// ---- verif/rcs_sequencer_monitor.sv ----
// Port checker for the command sequencer
`timescale 1ns/10ps
`include "rcs_cfg.svh"
module rcs_sequencer_monitor (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [`RCS_GUARD_W-1:0] receive_guard_delay_i,
  input wire logic rx_valid_i,
  input wire logic tx_ready_i,
  input wire logic fifo_pop_o,
  input wire logic tx_valid_o,
  input wire logic rx_enable_o,
  input wire logic fifo_push_o,
  input wire logic [7:0] active_cmd_o,
  input wire logic busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [8:0] wait_cnt;
  logic [7:0] dly;
  wire go = cmd_wr_i && active_cmd_o != 8'h3F;
  // Age of the last accepted write, so the guard delay is timed exactly
  always_ff @(posedge sys_clk_i)
  begin
    wait_cnt <= go ? 9'h001 : wait_cnt + 9'h001;
    dly <= go ? receive_guard_delay_i : dly;
  end
  chk_power_up_init_command_hold: assert property ($rose(resetn_i) |-> (busy_o && active_cmd_o == 8'h3F) [*8])
    else $error("power_up_init_command left early");
  chk_power_up_init_command_locked: assert property (cmd_wr_i && active_cmd_o == 8'h3F |=> active_cmd_o inside {8'h3F, 8'h00})
    else $error("power_up_init_command interrupted");
  chk_cmd_start: assert property (go && cmd_code_i inside {8'h1A, 8'h16} |=> busy_o && active_cmd_o == $past(cmd_code_i))
    else $error("command not taken");
  chk_idle_ends: assert property (go && cmd_code_i == 8'h00 |=> !busy_o && active_cmd_o == 8'h00)
    else $error("idle did not stop");
  chk_pop_spaced: assert property (fifo_pop_o |=> !fifo_pop_o)
    else $error("pops too close");
  chk_tx_holds: assert property (tx_valid_o && !tx_ready_i && !cmd_wr_i |=> tx_valid_o)
    else $error("tx byte dropped");
  chk_tx_no_rx: assert property (active_cmd_o == 8'h1A |-> !rx_enable_o)
    else $error("receiver on in transmit");
  // Load at the write edge, delay+1 edges to reach done, one more edge to
  // register the enable; the rise is seen one edge after that
  chk_guard_time: assert property ($rose(rx_enable_o) |-> wait_cnt == {1'b0, dly} + 9'h003)
    else $error("guard delay wrong");
  chk_rx_push: assert property (rx_valid_i && rx_enable_o && !cmd_wr_i |=> fifo_push_o)
    else $error("rx byte not pushed");
endmodule // rcs_sequencer_monitor
bind rcs_sequencer rcs_sequencer_monitor mon (.*);

// ---- verif/rcs_host_model.sv ----
// Host FIFO and transmitter model facing the sequencer
`timescale 1ns/10ps
module rcs_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       fifo_pop_i,
  input  wire logic       slow_i,
  output logic            fifo_valid_o = 1'b0,
  output logic [7:0]      fifo_data_o = 8'h00,
  output logic            tx_ready_o = 1'b0
);
  logic [7:0] q[$];
  logic [7:0] last = 8'h00;
  task automatic put(input logic [7:0] v);
    q.push_back(v);
  endtask
  // Head moves one cycle after a pop; an empty FIFO shows the inverse of the last byte
  always @(posedge sys_clk_i)
  begin
    if (fifo_pop_i && q.size() > 0) last = q.pop_front();
    fifo_valid_o <= q.size() > 0;
    fifo_data_o <= (q.size() > 0) ? q[0] : ~last;
    tx_ready_o <= !slow_i || ($urandom % 3 == 0);
  end
endmodule // rcs_host_model

// ---- verif/tb_reader_command_sequencer.sv ----
// Self-checking bench for the reader command sequencer
`timescale 1ns/10ps
module tb_reader_command_sequencer;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cmd_wr_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic slow = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic [7:0] rx_data_i = 8'h00;
  logic [7:0] receive_guard_delay_i = 8'h04;
  logic fifo_valid_i, fifo_pop_o, tx_ready_i, tx_valid_o, rx_enable_o, fifo_push_o, busy_o;
  logic [7:0] fifo_data_i, tx_data_o, fifo_wdata_o, active_cmd_o, b;
  logic [7:0] exp_tx[$], exp_rx[$];
  logic [7:0] codes[4] = '{8'h1A, 8'h16, 8'h55, 8'h00};
  logic [7:0] want[4] = '{8'h1A, 8'h16, 8'h00, 8'h00};
  int err_count = 0;
  int check_count = 0;
  int k;
  always #20 sys_clk_i = ~sys_clk_i;
  rcs_sequencer dut (
    .sys_clk_i             (sys_clk_i),
    .resetn_i              (resetn_i),
    .cmd_wr_i              (cmd_wr_i),
    .cmd_code_i            (cmd_code_i),
    .receive_guard_delay_i (receive_guard_delay_i),
    .fifo_valid_i          (fifo_valid_i),
    .fifo_data_i           (fifo_data_i),
    .fifo_pop_o            (fifo_pop_o),
    .tx_ready_i            (tx_ready_i),
    .tx_valid_o            (tx_valid_o),
    .tx_data_o             (tx_data_o),
    .rx_valid_i            (rx_valid_i),
    .rx_data_i             (rx_data_i),
    .rx_enable_o           (rx_enable_o),
    .fifo_push_o           (fifo_push_o),
    .fifo_wdata_o          (fifo_wdata_o),
    .active_cmd_o          (active_cmd_o),
    .busy_o                (busy_o)
  );
  rcs_host_model host (.sys_clk_i, .fifo_pop_i(fifo_pop_o), .slow_i(slow),
    .fifo_valid_o(fifo_valid_i), .fifo_data_o(fifo_data_i), .tx_ready_o(tx_ready_i));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // A bounded wait that ran out ends the run
  task automatic timeout(input int n);
    if (n >= 300)
    begin
      $display("unexpected wait: expected 1 seen 0");
      err_count++;
      summarize();
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] e);
    tick(1);
    cmd_wr_i = 1'b1;
    cmd_code_i = c;
    tick(1);
    cmd_wr_i = 1'b0;
    tick(1);
    chk("active_cmd", e, active_cmd_o);
  endtask
  // Reference model: queued bytes must come out in order
  always @(posedge sys_clk_i)
  begin
    if (tx_valid_o === 1'b1 && tx_ready_i) chk("tx_data", exp_tx.pop_front(), tx_data_o);
    if (fifo_push_o === 1'b1) chk("push_data", exp_rx.pop_front(), fifo_wdata_o);
  end
  initial
  begin
    void'($urandom(29));
    tick(10);
    chk("reset_cmd", 8'h3F, active_cmd_o);
    resetn_i = 1'b1;
    cmd(8'h1A, 8'h3F);
    for (k = 0; k < 300 && busy_o !== 1'b0; k++) tick(1);
    timeout(k);
    chk("power_up_init_command_end", 8'h00, active_cmd_o);
    $display("test power_up_init_command done");
    slow = 1'b1;
    // Four bytes wait in the FIFO before the write, two arrive while sending
    for (k = 0; k < 6; k++)
    begin
      b = 8'($urandom);
      host.put(b);
      exp_tx.push_back(b);
      if (k == 3) cmd(8'h1A, 8'h1A);
    end
    for (k = 0; k < 300 && exp_tx.size() > 0; k++) tick(1);
    timeout(k);
    $display("test transmit done");
    // Standalone receive, used here as a test only, aborts the transmit
    receive_guard_delay_i = 8'($urandom_range(12, 3));
    cmd(8'h16, 8'h16);
    chk("rx_early", 8'h00, {7'h00, rx_enable_o});
    for (k = 0; k < 300 && rx_enable_o !== 1'b1; k++) tick(1);
    timeout(k);
    for (k = 0; k < 3; k++)
    begin
      rx_valid_i = 1'b1;
      rx_data_i = 8'($urandom);
      exp_rx.push_back(rx_data_i);
      tick(1);
      rx_valid_i = 1'b0;
      rx_data_i = ~rx_data_i;
      tick(1);
    end
    chk("rx_left", 8'h00, 8'(exp_rx.size()));
    $display("test receive done");
    // Back-to-back writes, an unknown code acting as idle
    for (k = 0; k < 5; k++)
    begin
      tick(1);
      cmd_wr_i = (k < 4);
      if (k < 4) cmd_code_i = codes[k];
      if (k > 0) chk("burst_cmd", want[k - 1], active_cmd_o);
    end
    chk("idle_busy", 8'h00, {7'h00, busy_o});
    $display("test burst done");
    summarize();
  end
endmodule // tb_reader_command_sequencer
